// >>> inc/ppr_pkg.sv
// Package for the peripheral pin remap block: widths, codes and offsets.
package ppr_pkg;

  // Geometry of the pin and source arrays.
  localparam int NUM_PINS      = 8;
  localparam int OUT_SEL_W     = 6;
  localparam int IN_SEL_W      = 7;
  localparam int PIN_IDX_W     = 3;
  localparam int NUM_OUT_SRC   = 18;
  localparam int NUM_IN_SRC    = 4;
  localparam int NUM_IN_PINS   = 128;

  // Register bus geometry.
  localparam int ADDR_W        = 4;
  localparam int DATA_W        = 16;

  // Register offsets (word index on the plain port).
  localparam logic [3:0] OFS_OUT_MAP0  = 4'h0;
  localparam logic [3:0] OFS_OUT_MAP1  = 4'h1;
  localparam logic [3:0] OFS_OUT_MAP2  = 4'h2;
  localparam logic [3:0] OFS_OUT_MAP3  = 4'h3;
  localparam logic [3:0] OFS_SPI2_SS   = 4'h4;
  localparam logic [3:0] OFS_CAN_RX    = 4'h5;
  localparam logic [3:0] OFS_PWM_SYNC  = 4'h6;

  // Field positions inside a register.
  localparam int OUT_LO_LSB    = 0;
  localparam int OUT_HI_LSB    = 8;
  localparam int IN_LOW_LSB    = 0;
  localparam int IN_HIGH_LSB   = 8;

  // Reset value of every select field.
  localparam logic [5:0] OUT_SEL_RST = 6'h00;
  localparam logic [6:0] IN_SEL_RST  = 7'h00;

  // Output select codes.
  localparam logic [5:0] OSEL_NULL     = 6'h00;
  localparam logic [5:0] OSEL_UART_ONE_TRANSMIT_OUT     = 6'h01;
  localparam logic [5:0] OSEL_UART_TWO_TRANSMIT_OUT     = 6'h03;
  localparam logic [5:0] OSEL_SPI_TWO_DATA_OUT     = 6'h08;
  localparam logic [5:0] OSEL_SPI_TWO_CLOCK_OUT     = 6'h09;
  localparam logic [5:0] OSEL_SS2      = 6'h0a;
  localparam logic [5:0] OSEL_CANTX    = 6'h0e;
  localparam logic [5:0] OSEL_OC1      = 6'h10;
  localparam logic [5:0] OSEL_OC2      = 6'h11;
  localparam logic [5:0] OSEL_OC3      = 6'h12;
  localparam logic [5:0] OSEL_OC4      = 6'h13;
  localparam logic [5:0] OSEL_COMPARATOR_ONE_SOURCE     = 6'h18;
  localparam logic [5:0] OSEL_CMP2     = 6'h19;
  localparam logic [5:0] OSEL_CMP3     = 6'h1a;
  localparam logic [5:0] OSEL_SYNCO    = 6'h2d;
  localparam logic [5:0] OSEL_QEICMP   = 6'h2f;
  localparam logic [5:0] OSEL_REFCLK   = 6'h31;
  localparam logic [5:0] OSEL_CMP4     = 6'h32;

  // Input select codes.
  localparam logic [6:0] ISEL_GROUND   = 7'h00;
  localparam logic [6:0] ISEL_COMPARATOR_ONE_SOURCE     = 7'h01;
  localparam logic [6:0] ISEL_PIN_LO   = 7'h02;
  localparam logic [6:0] ISEL_PIN_121  = 7'h79;

endpackage

// >>> rtl/ppr_out_mux.sv
// Output source selector for one remappable pin.
`timescale 1ns/1ns
module ppr_out_mux (
  // Select field and variant straps.
  input  wire logic [5:0]  sel_i,
  input  wire logic        has_can_i,
  input  wire logic        has_motor_i,
  // Peripheral output sources.
  input  wire logic [17:0] src_i,
  // Pin drive.
  output logic             drive_o,
  output logic             active_o
);

  // Picks the source for the code; unknown codes give a null drive.
  always_comb begin
    drive_o  = 1'b0;
    active_o = 1'b1;
    case (sel_i)
      ppr_pkg::OSEL_UART_ONE_TRANSMIT_OUT:   drive_o = src_i[0];
      ppr_pkg::OSEL_UART_TWO_TRANSMIT_OUT:   drive_o = src_i[1];
      ppr_pkg::OSEL_SPI_TWO_DATA_OUT:   drive_o = src_i[2];
      ppr_pkg::OSEL_SPI_TWO_CLOCK_OUT:   drive_o = src_i[3];
      ppr_pkg::OSEL_SS2:    drive_o = src_i[4];
      ppr_pkg::OSEL_CANTX: begin
        drive_o  = src_i[5] & has_can_i;
        active_o = has_can_i;
      end
      ppr_pkg::OSEL_OC1:    drive_o = src_i[6];
      ppr_pkg::OSEL_OC2:    drive_o = src_i[7];
      ppr_pkg::OSEL_OC3:    drive_o = src_i[8];
      ppr_pkg::OSEL_OC4:    drive_o = src_i[9];
      ppr_pkg::OSEL_COMPARATOR_ONE_SOURCE:   drive_o = src_i[10];
      ppr_pkg::OSEL_CMP2:   drive_o = src_i[11];
      ppr_pkg::OSEL_CMP3:   drive_o = src_i[12];
      ppr_pkg::OSEL_CMP4:   drive_o = src_i[13];
      ppr_pkg::OSEL_SYNCO: begin
        drive_o  = src_i[14] & has_motor_i;
        active_o = has_motor_i;
      end
      ppr_pkg::OSEL_QEICMP: begin
        drive_o  = src_i[15] & has_motor_i;
        active_o = has_motor_i;
      end
      ppr_pkg::OSEL_REFCLK: drive_o = src_i[16];
      default: begin
        drive_o  = 1'b0;
        active_o = 1'b0;
      end
    endcase
  end

endmodule // ppr_out_mux

// >>> rtl/ppr_top.sv
// Peripheral pin remap: output and input routing with a register port.
//
// Operation
// - Each remappable pin picks its own output source from its field.
// - Output map registers hold 6-bit fields, one per pin.
// - Code zero is the reset value and means null output.
// - Any mapping combination is allowed, no lockouts.
// - Codes 1 and 3 select UART one and two transmit.
// - Codes 8, 9, 10 select SPI two data, clock, slave select.
// - Code 14 selects CAN transmit, only on CAN variants.
// - Codes 16 to 19 select compare units one to four.
// - Codes 24 to 26 select comparators one to three; 50 comparator four.
// - Codes 45 and 47 select sync out and encoder compare on motor parts.
// - Code 49 selects the reference clock output.
// - SPI two select input field sits in bits 6 to 0.
// - CAN receive input field sits in bits 6 to 0 on CAN parts.
// - Input code 0 is ground, 1 comparator one, 121 input-only pin.
// - Unused bits read zero; fields read, write and reset to zero.
`timescale 1ns/1ns
module ppr_top (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // Variant straps.
  input  wire logic        has_can_i,
  input  wire logic        has_motor_i,
  // Register port.
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Peripheral outputs to be routed.
  input  wire logic        uart_one_transmit_out_i,
  input  wire logic        uart_two_transmit_out_i,
  input  wire logic        spi_two_data_out_i,
  input  wire logic        spi_two_clock_out_i,
  input  wire logic        spi_two_slave_select_out_i,
  input  wire logic        can_transmit_out_i,
  input  wire logic [3:0]  compare_unit_out_i,
  input  wire logic [3:0]  comparator_out_i,
  input  wire logic        pwm_timebase_sync_out_i,
  input  wire logic        encoder_counter_compare_out_i,
  input  wire logic        reference_clock_out_i,
  // Remappable pin side.
  input  wire logic [7:0]  port_default_i,
  input  wire logic [127:0] remappable_pin_i,
  output logic      [7:0]  remappable_pin_o,
  output logic      [7:0]  remappable_pin_mapped_o,
  // Routed peripheral inputs.
  output logic             spi_two_slave_select_in_o,
  output logic             can_receive_in_o,
  output logic             pwm_sync_in_o
);

  // All register state of the block.
  typedef struct packed {
    logic [7:0][5:0] pin_output_select_field;
    logic [6:0]      spi2_select_source_field;
    logic [6:0]      can_receive_source_field;
    logic [6:0]      pwm_sync_in_source_field;
    logic [15:0]     rdata;
  } ppr_state_t;

  ppr_state_t state;
  ppr_state_t next_state;

  logic [17:0] out_src;
  logic [7:0]  pin_drive;
  logic [7:0]  pin_active;

  // Resolves one 7-bit input select code to a level.
  function automatic logic ppr_in_pick(input logic [6:0]   sel,
                                       input logic [127:0] pins,
                                       input logic         comparator_one_source);
    logic v;
    v = 1'b0;
    if (sel == ppr_pkg::ISEL_GROUND) begin
      v = 1'b0;
    end else if (sel == ppr_pkg::ISEL_COMPARATOR_ONE_SOURCE) begin
      v = comparator_one_source;
    end else if (sel <= ppr_pkg::ISEL_PIN_121) begin
      v = pins[sel];
    end else begin
      v = 1'b0;
    end
    return v;
  endfunction

  // Gathers the routable peripheral outputs in code order, except comparator four (code 50), which sits right after comparator three.
  assign out_src = {1'b0,
                    reference_clock_out_i,
                    encoder_counter_compare_out_i,
                    pwm_timebase_sync_out_i,
                    comparator_out_i[3],
                    comparator_out_i[2:0],
                    compare_unit_out_i,
                    can_transmit_out_i,
                    spi_two_slave_select_out_i,
                    spi_two_clock_out_i,
                    spi_two_data_out_i,
                    uart_two_transmit_out_i,
                    uart_one_transmit_out_i};

  // One selector per pin; no pin looks at another pin's field.
  for (genvar p = 0; p < ppr_pkg::NUM_PINS; p++) begin : g_pin
    ppr_out_mux u_mux (
      .sel_i       (state.pin_output_select_field[p]),
      .has_can_i   (has_can_i),
      .has_motor_i (has_motor_i),
      .src_i       (out_src),
      .drive_o     (pin_drive[p]),
      .active_o    (pin_active[p])
    );
  end

  // Unmapped pins fall back to their default port function.
  always_comb begin
    for (int p = 0; p < ppr_pkg::NUM_PINS; p++) begin
      remappable_pin_o[p] = pin_active[p] ? pin_drive[p]
                                          : port_default_i[p];
    end
  end
  assign remappable_pin_mapped_o = pin_active;

  // Peripheral inputs are routed combinationally from the fields.
  assign spi_two_slave_select_in_o =
    ppr_in_pick(state.spi2_select_source_field, remappable_pin_i,
                comparator_out_i[0]);
  assign can_receive_in_o = has_can_i &
    ppr_in_pick(state.can_receive_source_field, remappable_pin_i,
                comparator_out_i[0]);
  assign pwm_sync_in_o = has_motor_i &
    ppr_in_pick(state.pwm_sync_in_source_field, remappable_pin_i,
                comparator_out_i[0]);

  // Register writes and read data for the next cycle.
  always_comb begin
    next_state = state;
    next_state.rdata = 16'h0000;
    if (reg_wr_i) begin
      case (reg_addr_i)
        ppr_pkg::OFS_OUT_MAP0: begin
          next_state.pin_output_select_field[0] =
            reg_wdata_i[ppr_pkg::OUT_LO_LSB +: ppr_pkg::OUT_SEL_W];
          next_state.pin_output_select_field[1] =
            reg_wdata_i[ppr_pkg::OUT_HI_LSB +: ppr_pkg::OUT_SEL_W];
        end
        ppr_pkg::OFS_OUT_MAP1: begin
          next_state.pin_output_select_field[2] =
            reg_wdata_i[ppr_pkg::OUT_LO_LSB +: ppr_pkg::OUT_SEL_W];
          next_state.pin_output_select_field[3] =
            reg_wdata_i[ppr_pkg::OUT_HI_LSB +: ppr_pkg::OUT_SEL_W];
        end
        ppr_pkg::OFS_OUT_MAP2: begin
          next_state.pin_output_select_field[4] =
            reg_wdata_i[ppr_pkg::OUT_LO_LSB +: ppr_pkg::OUT_SEL_W];
          next_state.pin_output_select_field[5] =
            reg_wdata_i[ppr_pkg::OUT_HI_LSB +: ppr_pkg::OUT_SEL_W];
        end
        ppr_pkg::OFS_OUT_MAP3: begin
          next_state.pin_output_select_field[6] =
            reg_wdata_i[ppr_pkg::OUT_LO_LSB +: ppr_pkg::OUT_SEL_W];
          next_state.pin_output_select_field[7] =
            reg_wdata_i[ppr_pkg::OUT_HI_LSB +: ppr_pkg::OUT_SEL_W];
        end
        ppr_pkg::OFS_SPI2_SS: begin
          next_state.spi2_select_source_field =
            reg_wdata_i[ppr_pkg::IN_LOW_LSB +: ppr_pkg::IN_SEL_W];
        end
        ppr_pkg::OFS_CAN_RX: begin
          next_state.can_receive_source_field =
            reg_wdata_i[ppr_pkg::IN_LOW_LSB +: ppr_pkg::IN_SEL_W];
        end
        ppr_pkg::OFS_PWM_SYNC: begin
          next_state.pwm_sync_in_source_field =
            reg_wdata_i[ppr_pkg::IN_HIGH_LSB +: ppr_pkg::IN_SEL_W];
        end
        default: begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        ppr_pkg::OFS_OUT_MAP0: begin
          next_state.rdata = {2'h0, state.pin_output_select_field[1],
                              2'h0, state.pin_output_select_field[0]};
        end
        ppr_pkg::OFS_OUT_MAP1: begin
          next_state.rdata = {2'h0, state.pin_output_select_field[3],
                              2'h0, state.pin_output_select_field[2]};
        end
        ppr_pkg::OFS_OUT_MAP2: begin
          next_state.rdata = {2'h0, state.pin_output_select_field[5],
                              2'h0, state.pin_output_select_field[4]};
        end
        ppr_pkg::OFS_OUT_MAP3: begin
          next_state.rdata = {2'h0, state.pin_output_select_field[7],
                              2'h0, state.pin_output_select_field[6]};
        end
        ppr_pkg::OFS_SPI2_SS: begin
          next_state.rdata = {9'h000, state.spi2_select_source_field};
        end
        ppr_pkg::OFS_CAN_RX: begin
          next_state.rdata = {9'h000, state.can_receive_source_field};
        end
        ppr_pkg::OFS_PWM_SYNC: begin
          next_state.rdata = {1'b0, state.pwm_sync_in_source_field,
                              8'h00};
        end
        default: begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end
  end

  // Registers the state; reset clears every select field to null.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state.pin_output_select_field  <= {8{ppr_pkg::OUT_SEL_RST}};
      state.spi2_select_source_field <= ppr_pkg::IN_SEL_RST;
      state.can_receive_source_field <= ppr_pkg::IN_SEL_RST;
      state.pwm_sync_in_source_field <= ppr_pkg::IN_SEL_RST;
      state.rdata                    <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_o = state.rdata;

endmodule // ppr_top

// >>> verif/ppr_periph_model.sv
// Model of the peripherals and input pins around the remap block.
`timescale 1ns/1ns
module ppr_periph_model (
  // Clock and reset.
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  // Peripheral outputs and input pin levels.
  output logic      [16:0]  src_o,
  output logic      [127:0] pin_o
);
  // Levels wander so that every route is seen at both levels.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src_o <= 17'h05a3c;
      pin_o <= {8{16'hc3a5}};
    end else begin
      src_o <= {src_o[15:0], src_o[16] ^ src_o[13]};
      pin_o <= {pin_o[126:0], src_o[16] ^ pin_o[127]};
    end
  end
endmodule // ppr_periph_model

// >>> verif/ppr_top_asserts.sv
// Assertion checker for the pin remap top, bound to its ports.
`timescale 1ns/1ns
module ppr_top_asserts (
  // Clock, reset and straps.
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        has_can_i,
  input wire logic        has_motor_i,
  // Register port.
  input wire logic [3:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Sources and routed results.
  input wire logic        uart_one_transmit_out_i,
  input wire logic [3:0]  comparator_out_i,
  input wire logic [7:0]  port_default_i,
  input wire logic [7:0]  remappable_pin_o,
  input wire logic [7:0]  remappable_pin_mapped_o,
  input wire logic        spi_two_slave_select_in_o,
  input wire logic        can_receive_in_o,
  input wire logic        pwm_sync_in_o
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  AST_PIN0_UART1:
    assert property (reg_wr_i && reg_addr_i == 4'h0 &&
      reg_wdata_i[5:0] == 6'h01 |=> remappable_pin_mapped_o[0] &&
      remappable_pin_o[0] == uart_one_transmit_out_i)
    else $error("pin 0 not on uart one");
  AST_NULL_DEFAULT:
    assert property (((remappable_pin_o ^ port_default_i) &
      ~remappable_pin_mapped_o) == 8'h00)
    else $error("unmapped pin lost its default");
  AST_CAN_GATE:
    assert property (!has_can_i |-> !can_receive_in_o)
    else $error("can input live on part without can");
  AST_PWM_GATE:
    assert property (!has_motor_i |-> !pwm_sync_in_o)
    else $error("sync input live on part without motor");
  AST_SPI_COMPARATOR_ONE_SOURCE:
    assert property (reg_wr_i && reg_addr_i == 4'h4 &&
      reg_wdata_i[6:0] == 7'h01 |=>
      spi_two_slave_select_in_o == comparator_out_i[0])
    else $error("select input not on comparator one");
  AST_RD_IDLE:
    assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  AST_RD_UNMAPPED:
    assert property (reg_rd_i && reg_addr_i > 4'h6 |=>
      reg_rdata_o == 16'h0000)
    else $error("unmapped index read non zero");
  AST_READBACK:
    assert property (reg_wr_i && reg_addr_i == 4'h4 ##1 reg_rd_i &&
      reg_addr_i == 4'h4 |=> reg_rdata_o ==
      ($past(reg_wdata_i, 2) & 16'h007f))
    else $error("select field read back wrong");
  // Main scenarios seen.
  cover property (reg_wr_i && reg_addr_i == 4'h6);
  cover property (can_receive_in_o);
  cover property (remappable_pin_mapped_o[1]);
endmodule // ppr_top_asserts

bind ppr_top ppr_top_asserts ppr_top_asserts_i (.clk_sys_i, .nrst_i,
  .has_can_i, .has_motor_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .uart_one_transmit_out_i, .comparator_out_i,
  .port_default_i, .remappable_pin_o, .remappable_pin_mapped_o,
  .spi_two_slave_select_in_o, .can_receive_in_o, .pwm_sync_in_o);

// >>> verif/tb.sv
// Self-checking testbench for the peripheral pin remap block.
`timescale 1ns/1ns
module tb;
  logic         clk_sys_i = 1'b0;
  logic         nrst_i = 1'b0;
  logic         has_can_i = 1'b0;
  logic         has_motor_i = 1'b0;
  logic [3:0]   reg_addr_i = 4'h0;
  logic [15:0]  reg_wdata_i = 16'h0000;
  logic         reg_wr_i = 1'b0;
  logic         reg_rd_i = 1'b0;
  logic [7:0]   port_default_i = 8'h00;
  logic [15:0]  reg_rdata_o;
  logic [7:0]   pin_o;
  logic [7:0]   map_o;
  logic [2:0]   rin;
  logic [16:0]  src;
  logic [127:0] pins;
  logic [15:0]  sh [7] = '{default: 16'h0000};
  logic [15:0]  q [$];
  logic         rd_taken = 1'b0;
  logic [15:0]  rnd = 16'h0032;
  logic [6:0]   icode [9] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h40, 7'h78,
                              7'h79, 7'h7a, 7'h7f};
  int           n_mismatch = 0;
  int           n_compared = 0;

  // Clock of 100 ns.
  always #50 clk_sys_i = ~clk_sys_i;

  ppr_periph_model ppr_periph_model_i (.clk_sys_i, .nrst_i, .src_o(src),
    .pin_o(pins));
  ppr_top ppr_top_i (.clk_sys_i, .nrst_i, .has_can_i, .has_motor_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .uart_one_transmit_out_i(src[0]), .uart_two_transmit_out_i(src[1]),
    .spi_two_data_out_i(src[2]), .spi_two_clock_out_i(src[3]),
    .spi_two_slave_select_out_i(src[4]), .can_transmit_out_i(src[5]),
    .compare_unit_out_i(src[9:6]), .comparator_out_i(src[13:10]),
    .pwm_timebase_sync_out_i(src[14]),
    .encoder_counter_compare_out_i(src[15]),
    .reference_clock_out_i(src[16]), .port_default_i,
    .remappable_pin_i(pins), .remappable_pin_o(pin_o),
    .remappable_pin_mapped_o(map_o), .spi_two_slave_select_in_o(rin[2]),
    .can_receive_in_o(rin[1]), .pwm_sync_in_o(rin[0]));

  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Mapped flag and level for one output code; d is the default level.
  function automatic logic [1:0] oref(logic [5:0] c, logic d);
    case (c)
      6'h01: return {1'b1, src[0]};
      6'h03: return {1'b1, src[1]};
      6'h08, 6'h09, 6'h0a: return {1'b1, src[c - 6'h06]};
      6'h0e: return has_can_i ? {1'b1, src[5]} : {1'b0, d};
      6'h10, 6'h11, 6'h12, 6'h13: return {1'b1, src[c - 6'h0a]};
      6'h18, 6'h19, 6'h1a: return {1'b1, src[c - 6'h0e]};
      6'h32: return {1'b1, src[13]};
      6'h2d: return has_motor_i ? {1'b1, src[14]} : {1'b0, d};
      6'h2f: return has_motor_i ? {1'b1, src[15]} : {1'b0, d};
      6'h31: return {1'b1, src[16]};
      default: return {1'b0, d};
    endcase
  endfunction

  // Level of a routed input for one 7-bit code.
  function automatic logic iref(logic [6:0] c);
    if (c == 7'h01) return src[10];
    return (c > 7'h01 && c < 7'h7a) ? pins[c] : 1'b0;
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; notes the expected read and the new field values.
  task automatic bus(logic w, logic r, logic [3:0] a, logic [15:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    if (r) q.push_back(a < 4'h7 ? sh[a] : 16'h0000);
    rd_taken = r;
    if (w && a < 4'h4) sh[a] = d & 16'h3f3f;
    if (w && (a == 4'h4 || a == 4'h5)) sh[a] = d & 16'h007f;
    if (w && a == 4'h6) sh[a] = d & 16'h7f00;
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watches all routed outputs each cycle and read data after a read.
  always @(negedge clk_sys_i) begin
    logic [7:0] ep;
    logic [7:0] em;
    logic [1:0] o;
    logic [2:0] ei;
    if (nrst_i) begin
      for (int p = 0; p < 8; p++) begin
        o = oref(p[0] ? sh[p/2][13:8] : sh[p/2][5:0], port_default_i[p]);
        em[p] = o[1];
        ep[p] = o[0];
      end
      chk({8'h00, pin_o}, {8'h00, ep});
      chk({8'h00, map_o}, {8'h00, em});
      // Expected routed inputs; CAN receive and sync in are gated by the variant straps, SPI two select is not.
      ei = {iref(sh[4][6:0]), has_can_i & iref(sh[5][6:0]),
            has_motor_i & iref(sh[6][14:8])};
      chk({13'h0, rin}, {13'h0, ei});
      if (rd_taken) chk(reg_rdata_o, q.pop_front());
      else chk(reg_rdata_o, 16'h0000);
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_mismatch++;
    close_out();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int a = 0; a < 16; a++) bus(1'b0, 1'b1, a[3:0], 16'h0000);
    $display("test reset values done");
    for (int s = 0; s < 4; s++) begin
      has_can_i <= s[0];
      has_motor_i <= s[1];
      for (int c = 0; c < 64; c++) begin
        rnd = lfsr(rnd);
        port_default_i <= rnd[7:0];
        bus(1'b1, 1'b0, 4'h0, {rnd[15:14], ~c[5:0], rnd[7:6], c[5:0]});
        bus(1'b1, 1'b0, {2'b00, rnd[9:8]} + 4'h1, lfsr(rnd));
        bus(1'b0, 1'b1, 4'h0, 16'h0000);
      end
    end
    $display("test output codes done");
    foreach (icode[i]) for (int s = 0; s < 2; s++) begin
      has_can_i <= s[0];
      has_motor_i <= s[0];
      bus(1'b1, 1'b0, 4'h4, {9'h1ff, icode[i]});
      bus(1'b0, 1'b1, 4'h4, 16'h0000);
      bus(1'b1, 1'b0, 4'h5, {9'h1ff, icode[i]});
      bus(1'b1, 1'b0, 4'h6, {1'b1, icode[i], 8'hff});
      repeat (6) bus(1'b0, 1'b0, 4'h0, 16'h0000);
    end
    $display("test input codes done");
    repeat (300) begin
      rnd = lfsr(rnd);
      has_can_i <= rnd[5];
      has_motor_i <= rnd[6];
      port_default_i <= rnd[15:8];
      bus(rnd[0], ~rnd[0], rnd[4:1], lfsr(rnd ^ 16'ha5a5));
    end
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    $display("test random accesses done");
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    foreach (sh[i]) sh[i] = 16'h0000;
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int a = 0; a < 8; a++) bus(1'b0, 1'b1, a[3:0], 16'h0000);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    $display("test second reset done");
    close_out();
  end
endmodule // tb
